// ==== design/splg_ctrl.sv ====
// Self-program control and lock guard: arms store-program operations,
// times flash erase and write, and enforces the lock byte.
// Assumes the core drives one-cycle strobes and obeys the stall output.
// Overview of operation
// - Erase plus enable arms a page erase
// - Erase uses Z page, ignores data words
// - Erase select clears on finish or timeout
// - Core stalls while no-read-while-write section programs
// - Enable permits store only four cycles
// - Enable alone fills buffer word from pair
// - Enable clears after store or timeout
// - Enable stays high during erase or write
// - Unlisted command combinations are ignored
// - Only chip erase or reset returns lock bits to one
// - Lock byte six bits, default one
// - Memory lock mode one: no locking
// - Mode two blocks external programming, fuses
// - Mode three also blocks verify, boot locks
// - Application pair encodes four modes
// - Boot loads from application blocked modes 3,4
// - Application code interrupts blocked modes 3,4
// - Boot pair modes 2,3 forbid boot writes
// - Application loads from boot blocked modes 3,4
// - Boot code interrupts blocked modes 3,4
// - Three fuse bytes, programmed reads zero
// - Read-while-write section busy on erase or write
// - Control register resets to zero
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`include "splg_defines.svh"
module splg_ctrl #(
   parameter int OP_CYCLES = 100,
   parameter logic [7:0] BOOT_START_PAGE = 8'he0
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic store_i,
   input wire logic [15:0] zptr_i,
   input wire logic [15:0] regpair_i,
   input wire logic load_i,
   input wire logic exec_in_boot_i,
   input wire logic vectors_in_boot_i,
   input wire logic chip_erase_i,
   input wire logic ext_prog_i,
   input wire logic ext_verify_i,
   output logic stall_o,
   output logic rww_section_busy_o,
   output logic buf_we_o,
   output logic [5:0] buf_word_o,
   output logic [15:0] buf_data_o,
   output logic flash_erase_o,
   output logic flash_write_o,
   output logic [7:0] flash_page_o,
   output logic load_block_o,
   output logic irq_block_o,
   output logic [7:0] lock_o,
   output logic ext_prog_block_o,
   output logic ext_verify_block_o,
   output logic fuse_lock_o,
   output logic boot_lock_lock_o
);
   splg_pkg::splg_state_type r;
   splg_pkg::splg_state_type next_r;

   function automatic logic in_boot(input logic [15:0] z);
      in_boot = z[`SPLG_PAGE_MSB:`SPLG_PAGE_LSB] >= BOOT_START_PAGE;
   endfunction

   // Lock pairs are decoded for stores, loads and interrupts alike
   function automatic logic [1:0] app_mode(input logic [7:0] lk);
      app_mode = lk[`SPLG_APP_MSB:`SPLG_APP_LSB];
   endfunction

   function automatic logic [1:0] boot_mode(input logic [7:0] lk);
      boot_mode = lk[`SPLG_BOOT_MSB:`SPLG_BOOT_LSB];
   endfunction

   function automatic logic store_denied(input logic [15:0] z,
                                         input logic [7:0] lk);
      if (in_boot(z))
         store_denied = boot_mode(lk) == `SPLG_MODE_NOWR ||
                        boot_mode(lk) == `SPLG_MODE_BOTH;
      else
         store_denied = app_mode(lk) == `SPLG_MODE_NOWR ||
                        app_mode(lk) == `SPLG_MODE_BOTH;
   endfunction

   function automatic logic read_guard(input logic [1:0] m);
      read_guard = m == `SPLG_MODE_BOTH || m == `SPLG_MODE_NORD;
   endfunction

   logic [4:0] cmd;
   logic legal;
   logic denied;
   logic target_boot;
   always_comb
   begin
      cmd = wdata_i[4:0];
      legal = cmd == `SPLG_CMD_FILL || cmd == `SPLG_CMD_ERASE ||
              cmd == `SPLG_CMD_WRITE || cmd == `SPLG_CMD_LOCK ||
              cmd == `SPLG_CMD_REEN;
      denied = store_denied(zptr_i, r.lock);
      target_boot = in_boot(zptr_i);
      next_r = r;
      next_r.buf_we = 1'b0;
      next_r.flash_erase = 1'b0;
      next_r.flash_write = 1'b0;
      next_r.rdata = 8'h00;
      if (rd_i)
      begin
         case (addr_i)
            `SPLG_ADDR_CTRL: next_r.rdata = r.ctrl;
            `SPLG_ADDR_LOCK: next_r.rdata = r.lock;
            `SPLG_ADDR_FUSE_LO: next_r.rdata = r.fuse[7:0];
            `SPLG_ADDR_FUSE_HI: next_r.rdata = r.fuse[15:8];
            default: next_r.rdata = r.fuse[23:16];
         endcase
      end
      if (r.op_cnt != 16'h0000)
      begin
         next_r.op_cnt = r.op_cnt - 16'h0001;
         if (r.op_cnt == 16'h0001)
         begin
            next_r.ctrl[3:0] = 4'h0;
            next_r.core_hold = 1'b0;
         end
      end
      else if (r.arm_cnt != 3'h0)
      begin
         next_r.arm_cnt = r.arm_cnt - 3'h1;
         if (store_i)
         begin
            next_r.arm_cnt = 3'h0;
            next_r.ctrl[4:0] = 5'h00;
            if (r.ctrl[`SPLG_BIT_ERASE] || r.ctrl[`SPLG_BIT_WRITE])
            begin
               if (!denied)
               begin
                  // page from Z only, pair unused
                  next_r.flash_erase = r.ctrl[`SPLG_BIT_ERASE];
                  next_r.flash_write = r.ctrl[`SPLG_BIT_WRITE];
                  next_r.flash_page = zptr_i[`SPLG_PAGE_MSB:`SPLG_PAGE_LSB];
                  next_r.ctrl[`SPLG_BIT_EN] = 1'b1;
                  next_r.ctrl[`SPLG_BIT_ERASE] = r.ctrl[`SPLG_BIT_ERASE];
                  next_r.ctrl[`SPLG_BIT_WRITE] = r.ctrl[`SPLG_BIT_WRITE];
                  next_r.op_cnt = 16'(OP_CYCLES);
                  next_r.core_hold = target_boot;
                  if (!target_boot)
                     next_r.ctrl[`SPLG_BIT_BUSY] = 1'b1;
               end
            end
            else if (r.ctrl[`SPLG_BIT_LOCKSET])
               next_r.lock = r.lock &
                  {2'h3, regpair_i[`SPLG_BOOT_MSB:`SPLG_LB_ONE]};
            else if (r.ctrl[`SPLG_BIT_REEN])
               next_r.ctrl[`SPLG_BIT_BUSY] = 1'b0;
            else
            begin
               next_r.buf_we = 1'b1;
               next_r.buf_word = zptr_i[`SPLG_WORD_MSB:`SPLG_WORD_LSB];
               next_r.buf_data = regpair_i;
               next_r.ctrl[`SPLG_BIT_BUSY] = 1'b0;
            end
         end
         else if (r.arm_cnt == 3'h1)
            next_r.ctrl[4:0] = 5'h00;
      end
      if (wr_i && addr_i == `SPLG_ADDR_CTRL && r.op_cnt == 16'h0000 &&
          legal)
      begin
         next_r.ctrl[4:0] = cmd;
         next_r.arm_cnt = `SPLG_ARM_CYCLES;
      end
      next_r.load_blk = load_i && (exec_in_boot_i ?
         (!in_boot(zptr_i) && read_guard(app_mode(r.lock))) :
         (in_boot(zptr_i) && read_guard(boot_mode(r.lock))));
      next_r.irq_block = (vectors_in_boot_i && !exec_in_boot_i &&
                          read_guard(app_mode(r.lock))) ||
                         (!vectors_in_boot_i && exec_in_boot_i &&
                          read_guard(boot_mode(r.lock)));
      // Memory lock modes only gate the external programming path
      next_r.ext_prog_blk = !r.lock[`SPLG_LB_ONE];
      next_r.ext_ver_blk =
         r.lock[`SPLG_LB_TWO:`SPLG_LB_ONE] == `SPLG_MODE_BOTH;
      if (chip_erase_i)
         next_r.lock = `SPLG_LOCK_RESET;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r <= '0;
         r.ctrl <= `SPLG_CTRL_RESET;
         r.lock <= `SPLG_LOCK_RESET;
         r.fuse <= {3{`SPLG_FUSE_RESET}};
      end
      else
         r <= next_r;
   end

   assign rdata_o = r.rdata;
   assign stall_o = r.core_hold;
   assign rww_section_busy_o = r.ctrl[`SPLG_BIT_BUSY];
   assign buf_we_o = r.buf_we;
   assign buf_word_o = r.buf_word;
   assign buf_data_o = r.buf_data;
   assign flash_erase_o = r.flash_erase;
   assign flash_write_o = r.flash_write;
   assign flash_page_o = r.flash_page;
   assign load_block_o = r.load_blk;
   assign irq_block_o = r.irq_block;
   assign lock_o = r.lock;
   assign ext_prog_block_o = r.ext_prog_blk;
   assign ext_verify_block_o = r.ext_ver_blk;
   assign fuse_lock_o = r.ext_prog_blk;
   assign boot_lock_lock_o = r.ext_ver_blk;

   property p_arm_timeout;
      @(posedge clk_i) disable iff (rst_i)
      (wr_i && addr_i == `SPLG_ADDR_CTRL && r.op_cnt == 16'h0000 &&
       wdata_i[4:0] == `SPLG_CMD_ERASE) ##1 !store_i [*4]
      |=> r.ctrl[`SPLG_BIT_ERASE] == 1'b0;
   endproperty
   a_arm_timeout: assert property (p_arm_timeout)
      else $error("erase select not cleared after timeout");

   property p_enable_timeout;
      @(posedge clk_i) disable iff (rst_i)
      (wr_i && addr_i == `SPLG_ADDR_CTRL && r.op_cnt == 16'h0000 &&
       wdata_i[4:0] == `SPLG_CMD_FILL) ##1 (!store_i && !wr_i) [*4]
      |=> r.ctrl[`SPLG_BIT_EN] == 1'b0;
   endproperty
   a_enable_timeout: assert property (p_enable_timeout)
      else $error("enable not cleared after timeout");

   property p_erase_start;
      @(posedge clk_i) disable iff (rst_i)
      (r.arm_cnt != 3'h0 && r.op_cnt == 16'h0000 && store_i &&
       r.ctrl[4:0] == `SPLG_CMD_ERASE && !denied)
      |=> flash_erase_o && r.ctrl[`SPLG_BIT_EN];
   endproperty
   a_erase_start: assert property (p_erase_start)
      else $error("armed store did not start erase");

   property p_busy_enable;
      @(posedge clk_i) disable iff (rst_i)
      r.op_cnt > 16'h0001 |=> r.ctrl[`SPLG_BIT_EN];
   endproperty
   a_busy_enable: assert property (p_busy_enable)
      else $error("enable dropped during flash operation");

   property p_stall;
      @(posedge clk_i) disable iff (rst_i)
      stall_o |-> r.op_cnt != 16'h0000;
   endproperty
   a_stall: assert property (p_stall)
      else $error("stall outside flash operation");

   property p_illegal;
      @(posedge clk_i) disable iff (rst_i)
      (wr_i && addr_i == `SPLG_ADDR_CTRL && !legal && r.arm_cnt == 3'h0 &&
       r.op_cnt == 16'h0000) |=> r.arm_cnt == 3'h0;
   endproperty
   a_illegal: assert property (p_illegal)
      else $error("illegal command armed the block");

   property p_lock_sticky;
      @(posedge clk_i) disable iff (rst_i)
      !chip_erase_i |=> (r.lock & ~$past(r.lock)) == 8'h00;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky)
      else $error("lock bit returned to one without chip erase");

   property p_denied;
      @(posedge clk_i) disable iff (rst_i)
      (r.arm_cnt != 3'h0 && r.op_cnt == 16'h0000 && store_i && denied)
      |=> !flash_erase_o && !flash_write_o && r.ctrl[4:0] == 5'h00;
   endproperty
   a_denied: assert property (p_denied)
      else $error("forbidden store altered flash");

   property p_fill;
      @(posedge clk_i) disable iff (rst_i)
      (r.arm_cnt != 3'h0 && r.op_cnt == 16'h0000 && store_i &&
       r.ctrl[4:0] == `SPLG_CMD_FILL)
      |=> buf_we_o && buf_data_o == $past(regpair_i) &&
          buf_word_o == $past(zptr_i[`SPLG_WORD_MSB:`SPLG_WORD_LSB]);
   endproperty
   a_fill: assert property (p_fill)
      else $error("armed fill did not load the page buffer");

   // No disable here: the reset value itself is what is checked
   property p_ctrl_reset;
      @(posedge clk_i)
      rst_i |=> r.ctrl == `SPLG_CTRL_RESET;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset)
      else $error("control register not zero after reset");

   property p_lock_pad;
      @(posedge clk_i) disable iff (rst_i)
      r.lock[`SPLG_PAD_MSB:`SPLG_PAD_LSB] == 2'h3;
   endproperty
   a_lock_pad: assert property (p_lock_pad)
      else $error("unused lock bits left their default");

   property p_mode_free;
      @(posedge clk_i) disable iff (rst_i)
      r.lock[`SPLG_LB_TWO:`SPLG_LB_ONE] == `SPLG_MODE_FREE
      |=> !ext_prog_block_o && !ext_verify_block_o;
   endproperty
   a_mode_free: assert property (p_mode_free)
      else $error("memory lock applied in mode one");

   property p_mode_prog;
      @(posedge clk_i) disable iff (rst_i)
      !r.lock[`SPLG_LB_ONE] |=> ext_prog_block_o && fuse_lock_o;
   endproperty
   a_mode_prog: assert property (p_mode_prog)
      else $error("external programming or fuses left open");

   property p_mode_verify;
      @(posedge clk_i) disable iff (rst_i)
      r.lock[`SPLG_LB_TWO:`SPLG_LB_ONE] == `SPLG_MODE_BOTH
      |=> ext_verify_block_o && boot_lock_lock_o;
   endproperty
   a_mode_verify: assert property (p_mode_verify)
      else $error("verify or boot locks left open in mode three");

   property p_load_app;
      @(posedge clk_i) disable iff (rst_i)
      (load_i && exec_in_boot_i && !in_boot(zptr_i) &&
       read_guard(app_mode(r.lock))) |=> load_block_o;
   endproperty
   a_load_app: assert property (p_load_app)
      else $error("boot load read the application section");

   property p_load_boot;
      @(posedge clk_i) disable iff (rst_i)
      (load_i && !exec_in_boot_i && in_boot(zptr_i) &&
       read_guard(boot_mode(r.lock))) |=> load_block_o;
   endproperty
   a_load_boot: assert property (p_load_boot)
      else $error("application load read the boot section");

   property p_irq_app;
      @(posedge clk_i) disable iff (rst_i)
      (vectors_in_boot_i && !exec_in_boot_i &&
       read_guard(app_mode(r.lock))) |=> irq_block_o;
   endproperty
   a_irq_app: assert property (p_irq_app)
      else $error("interrupts open in locked application code");

   property p_irq_boot;
      @(posedge clk_i) disable iff (rst_i)
      (!vectors_in_boot_i && exec_in_boot_i &&
       read_guard(boot_mode(r.lock))) |=> irq_block_o;
   endproperty
   a_irq_boot: assert property (p_irq_boot)
      else $error("interrupts open in locked boot code");

   property p_rww_busy;
      @(posedge clk_i) disable iff (rst_i)
      (r.arm_cnt != 3'h0 && r.op_cnt == 16'h0000 && store_i && !denied &&
       (r.ctrl[4:0] == `SPLG_CMD_ERASE || r.ctrl[4:0] == `SPLG_CMD_WRITE) &&
       !in_boot(zptr_i)) |=> rww_section_busy_o;
   endproperty
   a_rww_busy: assert property (p_rww_busy)
      else $error("section busy not set on erase or write");
endmodule // splg_ctrl

// ==== design/splg_defines.svh ====
// Constants for the self-program control and lock guard block.
// Assumes inclusion by bare name from the design module.
`ifndef SPLG_DEFINES_SVH
`define SPLG_DEFINES_SVH
`define SPLG_ADDR_CTRL 2'h0
`define SPLG_ADDR_LOCK 2'h1
`define SPLG_ADDR_FUSE_LO 2'h2
`define SPLG_ADDR_FUSE_HI 2'h3
`define SPLG_BIT_EN 0
`define SPLG_BIT_ERASE 1
`define SPLG_BIT_WRITE 2
`define SPLG_BIT_LOCKSET 3
`define SPLG_BIT_REEN 4
`define SPLG_BIT_BUSY 6
`define SPLG_CMD_FILL 5'h01
`define SPLG_CMD_ERASE 5'h03
`define SPLG_CMD_WRITE 5'h05
`define SPLG_CMD_LOCK 5'h09
`define SPLG_CMD_REEN 5'h11
`define SPLG_ARM_CYCLES 3'h4
`define SPLG_CTRL_RESET 8'h00
`define SPLG_LOCK_RESET 8'hff
`define SPLG_FUSE_RESET 8'hff
`define SPLG_PAGE_LSB 7
`define SPLG_PAGE_MSB 14
`define SPLG_WORD_LSB 1
`define SPLG_WORD_MSB 6
`define SPLG_MODE_FREE 2'h3
`define SPLG_MODE_NOWR 2'h2
`define SPLG_MODE_BOTH 2'h0
`define SPLG_MODE_NORD 2'h1
`define SPLG_LB_ONE 0
`define SPLG_LB_TWO 1
`define SPLG_APP_LSB 2
`define SPLG_APP_MSB 3
`define SPLG_BOOT_LSB 4
`define SPLG_BOOT_MSB 5
`define SPLG_PAD_LSB 6
`define SPLG_PAD_MSB 7
`endif

// ==== design/splg_pkg.sv ====
// Types for the self-program control and lock guard block.
// Assumes the defines header is compiled alongside.
package splg_pkg;
   typedef enum {ST_IDLE, ST_ARMED, ST_BUSY} splg_phase_type;
   typedef struct packed
   {
      logic [7:0] ctrl;
      logic [7:0] lock;
      logic [23:0] fuse;
      logic [2:0] arm_cnt;
      logic [15:0] op_cnt;
      logic core_hold;
      logic [7:0] rdata;
      logic buf_we;
      logic [5:0] buf_word;
      logic [15:0] buf_data;
      logic flash_erase;
      logic flash_write;
      logic [7:0] flash_page;
      logic load_blk;
      logic irq_block;
      logic ext_prog_blk;
      logic ext_ver_blk;
   } splg_state_type;
endpackage

// ==== dv/splg_core_model.sv ====
// Core model: issues store-program and program-load instructions.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ns
module splg_core_model (
   input wire logic clk_i,
   output logic store_o,
   output logic load_o,
   output logic [15:0] zptr_o,
   output logic [15:0] regpair_o
);
   initial
   begin
      store_o = 1'b0;
      load_o = 1'b0;
      zptr_o = 16'h0000;
      regpair_o = 16'h0000;
   end
   // Store starts at the first edge after the call, inside the window
   task automatic store(input logic [15:0] z, input logic [15:0] r);
      @(posedge clk_i);
      store_o <= 1'b1;
      zptr_o <= z;
      regpair_o <= r;
      @(posedge clk_i);
      store_o <= 1'b0;
      // Released lines change, so stale operands cannot be reused
      zptr_o <= ~z;
      regpair_o <= ~r;
   endtask
   task automatic load(input logic [15:0] z);
      @(posedge clk_i);
      load_o <= 1'b1;
      zptr_o <= z;
      @(posedge clk_i);
      load_o <= 1'b0;
      zptr_o <= ~z;
   endtask
endmodule // splg_core_model

// ==== dv/splg_ctrl_tb_top.sv ====
// Bench for the self-program control and lock guard block.
// Assumes the core model in its own file; flash op shortened to 5.
`timescale 1ns/1ns
module splg_ctrl_tb_top;
   logic clk_i, rst_i, wr_i, rd_i, chip_erase_i;
   logic exec_in_boot_i, vectors_in_boot_i;
   logic [1:0] addr_i;
   logic [7:0] wdata_i, rdata_o, flash_page_o, lock_o;
   logic store_i, load_i, stall_o, rww_section_busy_o, buf_we_o;
   logic [15:0] zptr_i, regpair_i, buf_data_o;
   logic [5:0] buf_word_o;
   logic flash_erase_o, flash_write_o, load_block_o, irq_block_o;
   logic ext_prog_block_o, ext_verify_block_o, fuse_lock_o;
   logic boot_lock_lock_o;
   int failures = 0;
   int num_checks = 0;
   splg_ctrl #(.OP_CYCLES(5)) i_splg_ctrl (.clk_i(clk_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .store_i(store_i), .zptr_i(zptr_i),
      .regpair_i(regpair_i), .load_i(load_i),
      .exec_in_boot_i(exec_in_boot_i),
      .vectors_in_boot_i(vectors_in_boot_i),
      .chip_erase_i(chip_erase_i), .ext_prog_i(1'b0),
      .ext_verify_i(1'b0), .stall_o(stall_o),
      .rww_section_busy_o(rww_section_busy_o), .buf_we_o(buf_we_o),
      .buf_word_o(buf_word_o), .buf_data_o(buf_data_o),
      .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o),
      .flash_page_o(flash_page_o), .load_block_o(load_block_o),
      .irq_block_o(irq_block_o), .lock_o(lock_o),
      .ext_prog_block_o(ext_prog_block_o),
      .ext_verify_block_o(ext_verify_block_o),
      .fuse_lock_o(fuse_lock_o), .boot_lock_lock_o(boot_lock_lock_o));
   splg_core_model i_splg_core_model (.clk_i(clk_i), .store_o(store_i),
      .load_o(load_i), .zptr_o(zptr_i), .regpair_o(regpair_i));
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, input logic [7:0] exp,
                     input string what);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      check(what, 16'(rdata_o), 16'(exp));
   endtask
   initial
   begin
      repeat (2000) @(posedge clk_i);
      failures++;
      test_done();
   end
   initial
   begin
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 2'h0;
      wdata_i = 8'h00;
      chip_erase_i = 1'b0;
      exec_in_boot_i = 1'b0;
      vectors_in_boot_i = 1'b0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(2'h0, 8'h00, "ctrl");
      rd(2'h1, 8'hff, "lock");
      rd(2'h2, 8'hff, "fuse_lo");
      rd(2'h3, 8'hff, "fuse_hi");
      $display("test reset done");
      wr(2'h0, 8'h01);
      i_splg_core_model.store(16'h0007, 16'h1234);
      #1;
      check("buf_we", 16'(buf_we_o), 16'h0001);
      check("buf_word", 16'(buf_word_o), 16'h0003);
      check("buf_data", buf_data_o, 16'h1234);
      rd(2'h0, 8'h00, "ctrl");
      $display("test fill done");
      wr(2'h0, 8'h03);
      i_splg_core_model.store(16'h0280, 16'hdead);
      #1;
      check("erase", 16'(flash_erase_o), 16'h0001);
      check("page", 16'(flash_page_o), 16'h0005);
      check("buf_we", 16'(buf_we_o), 16'h0000);
      check("stall", 16'(stall_o), 16'h0000);
      check("busy", 16'(rww_section_busy_o), 16'h0001);
      rd(2'h0, 8'h43, "ctrl");
      repeat (8) @(posedge clk_i);
      rd(2'h0, 8'h40, "ctrl");
      wr(2'h0, 8'h11);
      i_splg_core_model.store(16'h0000, 16'h0000);
      rd(2'h0, 8'h00, "ctrl");
      $display("test erase done");
      wr(2'h0, 8'h01);
      repeat (5) @(posedge clk_i);
      rd(2'h0, 8'h00, "ctrl");
      wr(2'h0, 8'h03);
      repeat (5) @(posedge clk_i);
      rd(2'h0, 8'h00, "ctrl");
      i_splg_core_model.store(16'h7000, 16'h0000);
      #1;
      check("erase", 16'(flash_erase_o), 16'h0000);
      wr(2'h0, 8'h05);
      i_splg_core_model.store(16'h7000, 16'h0000);
      #1;
      check("write", 16'(flash_write_o), 16'h0001);
      check("page", 16'(flash_page_o), 16'h00e0);
      check("stall", 16'(stall_o), 16'h0001);
      repeat (8) @(posedge clk_i);
      #1;
      check("stall", 16'(stall_o), 16'h0000);
      rd(2'h0, 8'h00, "ctrl");
      wr(2'h0, 8'h07);
      rd(2'h0, 8'h00, "ctrl");
      $display("test write done");
      // Application locks go in before the memory lock bits
      wr(2'h0, 8'h09);
      i_splg_core_model.store(16'h0000, 16'h0033);
      rd(2'h1, 8'hf3, "lock");
      wr(2'h0, 8'h09);
      i_splg_core_model.store(16'h0000, 16'h0032);
      rd(2'h1, 8'hf2, "lock");
      check("ext_prog", 16'(ext_prog_block_o), 16'h0001);
      check("ext_ver", 16'(ext_verify_block_o), 16'h0000);
      check("fuse_lock", 16'(fuse_lock_o), 16'h0001);
      wr(2'h0, 8'h03);
      i_splg_core_model.store(16'h0280, 16'h0000);
      #1;
      check("erase", 16'(flash_erase_o), 16'h0000);
      rd(2'h0, 8'h00, "ctrl");
      @(posedge clk_i);
      exec_in_boot_i <= 1'b1;
      i_splg_core_model.load(16'h0100);
      #1;
      check("load_block", 16'(load_block_o), 16'h0001);
      @(posedge clk_i);
      exec_in_boot_i <= 1'b0;
      vectors_in_boot_i <= 1'b1;
      i_splg_core_model.load(16'h7000);
      #1;
      check("load_block", 16'(load_block_o), 16'h0000);
      check("irq_block", 16'(irq_block_o), 16'h0001);
      wr(2'h0, 8'h09);
      i_splg_core_model.store(16'h0000, 16'h003f);
      rd(2'h1, 8'hf2, "lock");
      wr(2'h0, 8'h09);
      i_splg_core_model.store(16'h0000, 16'h0000);
      i_splg_core_model.load(16'h7000);
      #1;
      check("load_block", 16'(load_block_o), 16'h0001);
      check("lock_o", 16'(lock_o), 16'h00c0);
      check("ext_ver", 16'(ext_verify_block_o), 16'h0001);
      check("boot_lock", 16'(boot_lock_lock_o), 16'h0001);
      @(posedge clk_i);
      exec_in_boot_i <= 1'b1;
      vectors_in_boot_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check("irq_block", 16'(irq_block_o), 16'h0001);
      wr(2'h0, 8'h05);
      i_splg_core_model.store(16'h7000, 16'h0000);
      #1;
      check("write", 16'(flash_write_o), 16'h0000);
      @(posedge clk_i);
      chip_erase_i <= 1'b1;
      @(posedge clk_i);
      chip_erase_i <= 1'b0;
      rd(2'h1, 8'hff, "lock");
      check("lock_o", 16'(lock_o), 16'h00ff);
      $display("test lock done");
      test_done();
   end
endmodule // splg_ctrl_tb_top
